// [core/mtp_pkg.sv]
package mtp_pkg;

  // Register map of the plain command port.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_WIDTH = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_COUNT = 4'h3;

  // Control register field positions.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_POLARITY_BIT = 1;
  localparam int CTRL_POSITION_BIT = 2;
  localparam int CTRL_INTERVAL_LSB = 4;
  localparam int CTRL_INTERVAL_MSB = 5;

  // Clock and pulse width timing.
  localparam int CLK_HZ = 20_000_000;
  localparam int WIDTH_MIN_US = 1;
  localparam int WIDTH_MAX_US = 1_000_000;
  localparam int US_PER_S = 1_000_000;
  localparam int CYC_PER_US = CLK_HZ / US_PER_S;
  localparam int WIDTH_W = 20;
  localparam logic [19:0] WIDTH_RESET_US = 20'h00001;
  localparam logic [19:0] WIDTH_MIN = 20'h00001;
  localparam logic [19:0] WIDTH_MAX = 20'hf4240;
  localparam logic [4:0] US_CYCLES = 5'(CYC_PER_US);

  // Which measurement interval a pulse belongs to.
  typedef enum logic [1:0] {
    MTP_IV_SCAN = 2'b00,
    MTP_IV_SECTION = 2'b01,
    MTP_IV_STEP = 2'b10,
    MTP_IV_PARTIAL = 2'b11
  } mtp_interval_t;

  // Placement of the pulse against the interval.
  localparam logic POS_BEFORE = 1'b0;
  localparam logic POS_AFTER = 1'b1;

  // Polarity encodings.
  localparam logic POL_LOW = 1'b0;
  localparam logic POL_HIGH = 1'b1;

  // Reset values.
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic POLARITY_RESET = POL_LOW;
  localparam logic POSITION_RESET = POS_AFTER;
  localparam mtp_interval_t INTERVAL_RESET = MTP_IV_SCAN;

  // Start and end strobes of each interval from the sweep engine.
  typedef struct packed {
    logic scan_start;
    logic scan_end;
    logic section_start;
    logic section_end;
    logic step_start;
    logic step_end;
    logic partial_start;
    logic partial_end;
  } mtp_sweep_events_t;

endpackage

// [core/mtp_pulse_timer.sv]
`timescale 1ns/10ps
`default_nettype none

// Counts a pulse width in microseconds, one prescaled tick per microsecond.
module mtp_pulse_timer (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [19:0] width_us_i,
  output logic busy_o
);

  logic [4:0] pre;
  logic [19:0] left;

  // Prescaler restarts with each pulse so the width is exact to the cycle.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre <= 5'h00;
      left <= 20'h00000;
      busy_o <= 1'b0;
    end else if (start_i) begin
      pre <= mtp_pkg::US_CYCLES - 5'h01;
      left <= width_us_i;
      busy_o <= 1'b1;
    end else if (busy_o) begin
      if (pre == 5'h00) begin
        pre <= mtp_pkg::US_CYCLES - 5'h01;
        if (left == 20'h00001) begin
          busy_o <= 1'b0;
        end
        left <= left - 20'h00001;
      end else begin
        pre <= pre - 5'h01;
      end
    end
  end

endmodule // mtp_pulse_timer

`default_nettype wire

// [core/mtp_trigger_out.sv]
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Pulse width programmable 1 us to 1 s, reset value 1 us.
// - Output enable per channel; disabled means no pulses; off at reset.
// - One pulse per scan, section, step or partial step; scan at reset.
// - Polarity active high or active low; active low at reset.
// - Pulse placed before or after the interval; after at reset.
// - Before placement pulses ahead of acquisition of the interval.
// - After placement pulses as soon as acquisition of interval ends.
module mtp_trigger_out (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire mtp_pkg::mtp_sweep_events_t events_i,
  output logic rear_pulse_output_o,
  output logic pulse_active_o
);

  logic enable;
  logic polarity;
  logic position;
  mtp_pkg::mtp_interval_t interval;
  logic [19:0] width_us;
  logic [15:0] pulse_count;
  logic fire;
  logic busy;
  logic ev_start;
  logic ev_end;
  logic wr_ctrl;
  logic wr_width;
  logic wr_count;
  logic pulse_on;
  logic [19:0] next_width;
  logic [15:0] next_count;
  logic [31:0] next_rdata;

  // One write strobe per writable register, decoded once for all its writers.
  // Unmapped addresses decode to nothing, so such writes are ignored.
  assign wr_ctrl = wr_i && (addr_i == mtp_pkg::ADDR_CTRL);
  assign wr_width = wr_i && (addr_i == mtp_pkg::ADDR_WIDTH);
  assign wr_count = wr_i && (addr_i == mtp_pkg::ADDR_COUNT);

  // Channel output enable.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable <= mtp_pkg::ENABLE_RESET;
    end else if (wr_ctrl) begin
      enable <= wdata_i[mtp_pkg::CTRL_ENABLE_BIT];
    end
  end

  // Pulse polarity; a change in mid-pulse flips the pin one clock after this register updates.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      polarity <= mtp_pkg::POLARITY_RESET;
    end else if (wr_ctrl) begin
      polarity <= wdata_i[mtp_pkg::CTRL_POLARITY_BIT];
    end
  end

  // Placement of the pulse against its interval.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      position <= mtp_pkg::POSITION_RESET;
    end else if (wr_ctrl) begin
      position <= wdata_i[mtp_pkg::CTRL_POSITION_BIT];
    end
  end

  // Interval selection; all four codes are legal choices.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      interval <= mtp_pkg::INTERVAL_RESET;
    end else if (wr_ctrl) begin
      interval <= mtp_pkg::mtp_interval_t'(
        wdata_i[mtp_pkg::CTRL_INTERVAL_MSB:mtp_pkg::CTRL_INTERVAL_LSB]);
    end
  end

  // Out of range widths are clamped rather than refused, so the timer
  // never holds a width that it cannot count.
  always_comb begin
    if (wdata_i[31:20] != 12'h000) begin
      next_width = mtp_pkg::WIDTH_MAX;
    end else if (wdata_i[19:0] < mtp_pkg::WIDTH_MIN) begin
      next_width = mtp_pkg::WIDTH_MIN;
    end else if (wdata_i[19:0] > mtp_pkg::WIDTH_MAX) begin
      next_width = mtp_pkg::WIDTH_MAX;
    end else begin
      next_width = wdata_i[19:0];
    end
  end

  // Pulse width in microseconds.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      width_us <= mtp_pkg::WIDTH_RESET_US;
    end else if (wr_width) begin
      width_us <= next_width;
    end
  end

  // Pick the start and end strobes of the selected interval.
  always_comb begin
    case (interval)
      mtp_pkg::MTP_IV_SCAN: begin
        ev_start = events_i.scan_start;
        ev_end = events_i.scan_end;
      end
      mtp_pkg::MTP_IV_SECTION: begin
        ev_start = events_i.section_start;
        ev_end = events_i.section_end;
      end
      mtp_pkg::MTP_IV_STEP: begin
        // Step strobes, not partial ones, so a step pulses only once.
        ev_start = events_i.step_start;
        ev_end = events_i.step_end;
      end
      mtp_pkg::MTP_IV_PARTIAL: begin
        ev_start = events_i.partial_start;
        ev_end = events_i.partial_end;
      end
      default: begin
        ev_start = 1'b0;
        ev_end = 1'b0;
      end
    endcase
  end

  // A pulse starts on the interval's start or end, per placement.
  // A new event during a running pulse is dropped; width must be short.
  assign fire = enable && !busy &&
    ((position == mtp_pkg::POS_BEFORE && ev_start) ||
     (position == mtp_pkg::POS_AFTER && ev_end));

  // The timer is not stopped by a cleared enable: it runs out silently.
  // A quick re-enable therefore shows the rest of a running pulse, which
  // is the price of keeping the timer free of any abort path.
  mtp_pulse_timer u_timer (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .start_i(fire),
    .width_us_i(width_us),
    .busy_o(busy)
  );

  // Active level in the fire cycle and while the timer runs, if the channel is enabled.
  assign pulse_on = (fire || busy) && enable;

  // The pin is registered so that it never glitches on strobe changes.
  // It starts in the cycle after the fire cycle, one clock after the strobe edge,
  // and sits at the inactive level of the polarity otherwise.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rear_pulse_output_o <= ~mtp_pkg::POLARITY_RESET;
      pulse_active_o <= 1'b0;
    end else begin
      pulse_active_o <= pulse_on;
      if (pulse_on) begin
        rear_pulse_output_o <= polarity;
      end else begin
        rear_pulse_output_o <= ~polarity;
      end
    end
  end

  // A pulse fired in the cycle of a clear is still counted, so software
  // never loses a pulse to a badly timed clear.
  always_comb begin
    if (wr_count) begin
      next_count = 16'h0000;
    end else begin
      next_count = pulse_count;
    end
    if (fire) begin
      next_count = next_count + 16'h0001;
    end
  end

  // Counts issued pulses so software can watch activity.
  // The counter wraps silently at 16 bits.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pulse_count <= 16'h0000;
    end else begin
      pulse_count <= next_count;
    end
  end

  // Read mux; unmapped addresses and idle cycles give zero.
  always_comb begin
    next_rdata = 32'h00000000;
    if (rd_i) begin
      case (addr_i)
        mtp_pkg::ADDR_CTRL: next_rdata = {26'h0, interval, 1'b0,
                                          position, polarity, enable};
        mtp_pkg::ADDR_WIDTH: next_rdata = {12'h000, width_us};
        mtp_pkg::ADDR_STATUS: next_rdata = {31'h0, busy};
        mtp_pkg::ADDR_COUNT: next_rdata = {16'h0000, pulse_count};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // Read data appear the cycle after the strobe and only then.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule // mtp_trigger_out

`default_nettype wire

// [test/mtp_meter.sv]
`timescale 1ns/10ps
`default_nettype none
// Counts pulses of 20 cycles or more, so polarity-change steps are ignored.
module mtp_meter (
  input wire logic core_clk_i,
  input wire logic pin_i,
  input wire logic pol_i,
  output int hits_o
);
  int run = 0;
  int count = 0;
  assign hits_o = count;
  // A run of 20 or more cycles at the active level ends with a count.
  always @(posedge core_clk_i) begin
    if (pin_i === pol_i) begin
      run <= run + 1;
    end else begin
      if (run >= 20) count <= count + 1;
      run <= 0;
    end
  end
endmodule // mtp_meter
`default_nettype wire

// [test/mtp_trigger_out_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
// Tracks the control word as written, since the checker sees only ports.
module mtp_trigger_out_monitor (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire mtp_pkg::mtp_sweep_events_t events_i,
  input wire logic rear_pulse_output_o,
  input wire logic pulse_active_o
);
  logic [5:0] c;
  logic w1;
  // Shadow copies; w1 marks a one microsecond width.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      c <= 6'h04;
      w1 <= 1'b1;
    end else if (wr_i && addr_i == mtp_pkg::ADDR_CTRL) begin
      c <= wdata_i[5:0];
    end else if (wr_i && addr_i == mtp_pkg::ADDR_WIDTH) begin
      w1 <= (wdata_i < 32'h2);
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_off; !c[0] && !$past(c[0]) |-> !pulse_active_o; endproperty
  a_off: assert property (p_off) else $error("pulse while off");
  property p_wid;
    $rose(pulse_active_o) && w1 |-> ##20 pulse_active_o ##1 !pulse_active_o;
  endproperty
  a_wid: assert property (p_wid) else $error("bad width");
  property p_aft;
    c[0] && c[5:2] == 4'h1 && events_i.scan_end && !pulse_active_o
      |=> pulse_active_o;
  endproperty
  a_aft: assert property (p_aft) else $error("no pulse");
  property p_bef;
    c[0] && c[5:2] == 4'h8 && events_i.step_start && !pulse_active_o
      |=> pulse_active_o;
  endproperty
  a_bef: assert property (p_bef) else $error("no early pulse");
  property p_stp;
    c[5:2] == 4'h9 && events_i.partial_end && !pulse_active_o
      |=> !pulse_active_o;
  endproperty
  a_stp: assert property (p_stp) else $error("partial pulse");
  property p_pol;
    pulse_active_o && $stable(c[1]) |-> rear_pulse_output_o == c[1];
  endproperty
  a_pol: assert property (p_pol) else $error("bad level");
  property p_idl;
    !pulse_active_o && $stable(c[1]) |-> rear_pulse_output_o != c[1];
  endproperty
  a_idl: assert property (p_idl) else $error("bad idle");
  property p_rdz; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("stray read data");
  c_bef: cover property ($rose(pulse_active_o) && !c[2]);
  c_aft: cover property ($rose(pulse_active_o) && c[2]);
  c_hi: cover property (pulse_active_o && c[1]);
endmodule // mtp_trigger_out_monitor
`default_nettype wire

// [test/tb_mtp_trigger_out.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_mtp_trigger_out;
  logic clk, rstn, wr, rd, pol, pin, act;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] ev;
  int fail_count = 0, n_compared = 0, cyc = 0, hits;
  mtp_trigger_out i_mtp_trigger_out (.core_clk_i(clk), .resetn_i(rstn),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .events_i(ev), .rear_pulse_output_o(pin), .pulse_active_o(act));
  mtp_meter i_mtp_meter (.core_clk_i(clk), .pin_i(pin), .pol_i(pol),
    .hits_o(hits));
  task close_out;
    $display("compared %0d, wrong %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value at %0t: %h %h", $time, s, e);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk(rdata, e);
  endtask
  // One strobe, then the pin is watched until it must be idle again.
  task fire(input int b, input int e);
    int n;
    n = 0;
    @(posedge clk) ev <= 8'h1 << b;
    @(posedge clk) ev <= 8'h0;
    repeat (60) begin
      @(negedge clk) n += (act === 1'b1);
      chk(pin, pol ^ (act !== 1'b1));
    end
    chk(n, e);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // A hang is counted as a mismatch.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin fail_count++; close_out; end
  end
  initial begin
    {rstn, wr, rd, addr, wdata, ev, pol} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(mtp_pkg::ADDR_CTRL, 32'h4);
    rd_reg(mtp_pkg::ADDR_WIDTH, 32'h1);
    rd_reg(4'hf, 32'h0);
    fire(6, 0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      pol = i[0];
      wr_reg(mtp_pkg::ADDR_CTRL, 32'((i >> 1) * 16 + i[0] * 6 + 1));
      fire(6 - (i & 6) + i[0], 0);
      fire(7 - (i & 6) - i[0], 21);
    end
    $display("test intervals done");
    wr_reg(mtp_pkg::ADDR_CTRL, 32'h27);
    fire(0, 0);
    wr_reg(mtp_pkg::ADDR_WIDTH, 32'h2);
    fire(2, 41);
    rd_reg(mtp_pkg::ADDR_COUNT, 32'h9);
    chk(hits, 9);
    @(posedge clk) ev <= 8'h4;
    @(posedge clk) ev <= 8'h0;
    rd_reg(mtp_pkg::ADDR_STATUS, 32'h1);
    repeat (50) @(posedge clk);
    rd_reg(mtp_pkg::ADDR_STATUS, 32'h0);
    wr_reg(mtp_pkg::ADDR_COUNT, 32'h0);
    rd_reg(mtp_pkg::ADDR_COUNT, 32'h0);
    wr_reg(mtp_pkg::ADDR_WIDTH, 32'h0);
    rd_reg(mtp_pkg::ADDR_WIDTH, 32'(mtp_pkg::WIDTH_MIN));
    wr_reg(mtp_pkg::ADDR_WIDTH, 32'hffffffff);
    rd_reg(mtp_pkg::ADDR_WIDTH, 32'(mtp_pkg::WIDTH_MAX));
    $display("test width done");
    close_out;
  end
endmodule // tb_mtp_trigger_out
bind mtp_trigger_out mtp_trigger_out_monitor i_mtp_trigger_out_monitor (.*);
`default_nettype wire
